// File: tpp_pkg.sv
// Shared constants and types of the trapezoid pulse positioner.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package tpp_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam logic [31:0] CLK_HZ        = 32'(1000000000 / CLK_PERIOD_NS);
  // Period of the 1.5 Hz speed that a setting of one stands for
  localparam int unsigned PER_1P5       = ((2 * 1000000000 / CLK_PERIOD_NS) + 2) / 3;

  // ****************************************************
  // Register byte offsets and fields
  // ****************************************************
  localparam logic [5:0] A_PCW   = 6'h00;
  localparam logic [5:0] A_COPY0 = 6'h04;
  localparam logic [5:0] A_COPY1 = 6'h08;
  localparam logic [5:0] A_CODE  = 6'h0C;
  localparam logic [5:0] A_F0    = 6'h10;
  localparam logic [5:0] A_FMAX  = 6'h14;
  localparam logic [5:0] A_RAMP  = 6'h18;
  localparam logic [5:0] A_TGT   = 6'h1C;
  localparam logic [5:0] A_START = 6'h20;
  localparam logic [5:0] A_STAT  = 6'h24;
  localparam logic [5:0] A_POSL  = 6'h28;
  localparam logic [5:0] A_POSH  = 6'h2C;
  localparam int unsigned PCW_CH   = 0;
  localparam int unsigned PCW_STOP = 3;

  // ****************************************************
  // Ramp steps and frequency limits
  // ****************************************************
  localparam logic [6:0]  N30    = 7'h1E;
  localparam logic [6:0]  N60    = 7'h3C;
  localparam logic [31:0] R0_LO  = 32'h1;
  localparam logic [31:0] R0_HI  = 32'h2648;
  localparam logic [31:0] R1_LO  = 32'h30;
  localparam logic [31:0] R2_LO  = 32'hBF;
  localparam logic [31:0] R12_HI = 32'h186A0;

  // ****************************************************
  // Types
  // ****************************************************
  // Control word, six hex digits from the top
  typedef struct packed {
    logic [3:0] zero;
    logic [3:0] steps;
    logic [3:0] duty;
    logic [3:0] frange;
    logic [3:0] absm;
    logic [3:0] scheme;
  } tpp_code_t;

  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_DSTEP  = 5'h02,
    S_DDELTA = 5'h04,
    S_DPER   = 5'h08,
    S_RUN    = 5'h10
  } tpp_state_t;

  // Divider state
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [32:0] rem;
    logic [31:0] q;
    logic [31:0] d;
  } tpp_dv_t;

  localparam tpp_dv_t DV_RST = '0;

  // Positioner state, held in one register
  typedef struct packed {
    tpp_state_t  st;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] pcw;
    logic [15:0] copy0;
    logic [15:0] copy1;
    tpp_code_t   code;
    logic [31:0] f0;
    logic [31:0] fmax;
    logic [15:0] ramp;
    logic [31:0] tgt;
    logic [31:0] pos;
    logic        busy;
    logic        done;
    logic        err;
    logic        dir;
    logic [31:0] remain;
    logic [31:0] spd;
    logic [31:0] delta;
    logic [31:0] stepms;
    logic [31:0] mscnt;
    logic [31:0] msn;
    logic [6:0]  k;
    logic        upd;
    logic [31:0] acc;
    logic [31:0] per;
    logic [31:0] pcnt;
    logic        pl;
    logic        fwd;
    logic        rev;
    logic        dstart;
    logic [31:0] dnum;
    logic [31:0] dden;
  } tpp_st_t;

  localparam tpp_st_t ST_RST = '{st: S_IDLE, default: '0};

  // Clamp a speed into the selected range; software limits are not trusted
  function automatic logic [31:0] clampf(input logic [3:0] rg, input logic [31:0] f);
    logic [31:0] lo;
    logic [31:0] up;
    lo = (rg == 4'h0) ? R0_LO : (rg == 4'h1) ? R1_LO : R2_LO;
    up = (rg == 4'h0) ? R0_HI : R12_HI;
    clampf = (f < lo) ? lo : (f > up) ? up : f;
  endfunction

endpackage

// File: tpp_div.sv
// Serial restoring divider, one quotient bit per enabled clock.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module tpp_div (
  input  wire logic        clk,     // System clock
  input  wire logic        sys_rst, // Synchronous reset
  input  wire logic        ce,      // Clock enable
  input  wire logic        start,   // Launch a divide
  input  wire logic [31:0] num,     // Dividend
  input  wire logic [31:0] den,     // Divisor
  output logic             done,    // Result valid pulse
  output logic [31:0]      quot     // Quotient
);
  import tpp_pkg::*;

  tpp_dv_t r;
  tpp_dv_t n;
  logic [32:0] t;

  // ****************************************************
  // Next state
  // ****************************************************
  // Zero divisor gives all ones, which later clamps harmlessly
  always_comb begin
    n = r;
    n.done = 1'b0;
    t = {r.rem[31:0], r.q[31]};
    if (start) begin
      n.busy = 1'b1;
      n.cnt = 6'h20;
      n.rem = '0;
      n.q = num;
      n.d = den;
    end else if (r.busy) begin
      if (t >= {1'b0, r.d}) begin
        n.rem = t - {1'b0, r.d};
        n.q = {r.q[30:0], 1'b1};
      end else begin
        n.rem = t;
        n.q = {r.q[30:0], 1'b0};
      end
      n.cnt = r.cnt - 6'h1;
      if (r.cnt == 6'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  // Registered state
  always_ff @(posedge clk) begin
    if (sys_rst) r <= DV_RST;
    else if (ce) r <= n;
  end

  assign done = r.done;
  assign quot = r.q;

endmodule // tpp_div

// File: tpp_positioner.sv
// Trapezoidal pulse-train positioner with elapsed position counter.
// Assumes an Avalon-MM master on clk and a pulse-input motor driver.
// What this block does
// [RULE1] Elapsed position is 32 bits, read as two 16-bit words, low first.
// [RULE2] Software loads position only by one full 32-bit write.
// [RULE3] Control word writes keep a copy per addressed channel.
// [RULE4] Start reads table, accelerates, runs, decelerates, ends at count.
// [RULE5] Software keeps ramp ms at least steps times 1000 over initial speed.
// [RULE6] Steps field: zero gives 30 steps, one gives 60 steps.
// [RULE7] Duty field: zero gives half period high, one quarter.
// [RULE8] Range field selects 1.5Hz-9.8kHz, 48Hz-100kHz or 191Hz-100kHz.
// [RULE9] Mode codes 00,02,03 incremental, 10,12,13 absolute output schemes.
// [RULE10] Speeds are integer hertz clamped to range; one means 1.5 Hz.
// [RULE11] Software keeps initial speed at or below 30 kHz.
// [RULE12] Software keeps ramp time 30/60 to 32760 ms in step units.
// [RULE13] Ramp time rounds up to whole 30 or 60 ms units.
// [RULE14] Target is a signed 32-bit count over the full range.
// [RULE15] Software picks quarter duty at 50 Hz and above.
// [RULE16] Software performs home return after a stop halted output.
// [RULE17] Incremental: positive target forward counting up, negative reverse.
// [RULE18] Absolute: emit target minus position, direction from its sign.
// [RULE19] Control word digits: zero, steps, duty, range, two mode digits.
// [RULE20] Position moves by exactly one per emitted pulse; a pulse cut by stop resumes as a second pulse for the same step.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module tpp_positioner #(
  parameter int unsigned MS_CYCLES = tpp_pkg::MS_CYC,  // Cycles per ms
  parameter int unsigned PER_SLOW  = tpp_pkg::PER_1P5  // 1.5 Hz period
) (
  input  wire logic        clk,               // System clock
  input  wire logic        sys_rst,           // Synchronous reset
  input  wire logic        ce,                // Clock enable
  input  wire logic [5:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [31:0] avs_writedata,     // Write data
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes
  output logic [31:0]      avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall
  output logic             forward_pulse_out, // Forward pulse
  output logic             reverse_pulse_out, // Reverse pulse or direction
  output logic             positioning_busy   // Move in progress
);
  import tpp_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  tpp_st_t     r;
  tpp_st_t     n;
  logic        ddone;
  logic [31:0] dq;
  logic        req;
  logic        wr;
  logic        go;
  logic        stop;
  logic        mode_ok;
  logic        endp;
  logic        dec;
  logic        stp;
  logic [6:0]  nst;
  logic [6:0]  nk;
  logic [31:0] nst32;
  logic [31:0] hi;
  logic [31:0] diff;
  logic [31:0] mag;
  logic [31:0] nspd;
  logic [31:0] wm;

  // Register read view
  function automatic logic [31:0] rdmux(input tpp_st_t s, input logic [5:0] a);
    case (a)
      A_PCW:   rdmux = {16'h0000, s.pcw};
      A_COPY0: rdmux = {16'h0000, s.copy0};
      A_COPY1: rdmux = {16'h0000, s.copy1};
      A_CODE:  rdmux = {12'h000, s.code[19:0]}; // [RULE19]
      A_F0:    rdmux = s.f0;
      A_FMAX:  rdmux = s.fmax;
      A_RAMP:  rdmux = {16'h0000, s.ramp};
      A_TGT:   rdmux = s.tgt;
      A_STAT:  rdmux = {20'h00000, s.k, s.dir, s.pcw[PCW_STOP], s.err, s.done, s.busy};
      A_POSL:  rdmux = {16'h0000, s.pos[15:0]};  // [RULE1]
      A_POSH:  rdmux = {16'h0000, s.pos[31:16]}; // [RULE1]
      default: rdmux = 32'h0;
    endcase
  endfunction

  // Byte-lane merge
  function automatic logic [31:0] bem(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    for (int i = 0; i < 4; i++) bem[8*i +: 8] = be[i] ? w[8*i +: 8] : o[8*i +: 8];
  endfunction

  // ****************************************************
  // Helpers
  // ****************************************************
  assign req = avs_read | avs_write;
  assign wr = avs_write & r.ack & ce;
  assign wm = bem(rdmux(r, avs_address), avs_writedata, avs_byteenable);
  assign go = wr && (avs_address == A_START) && wm[0] && !r.busy;
  assign stop = r.copy0[PCW_STOP];
  assign nst = r.code.steps[0] ? N60 : N30; // [RULE6]
  assign nst32 = {25'h0, nst};
  assign hi = r.code.duty[0] ? (r.per >> 2) : (r.per >> 1); // [RULE7]
  assign endp = (r.pcnt == r.per - 32'h1);
  assign diff = r.code.absm[0] ? (r.tgt - r.pos) : r.tgt; // [RULE18]
  assign mag = diff[31] ? (32'h0 - diff) : diff; // [RULE14]
  assign mode_ok = (r.code.zero == 4'h0) && (r.code.steps <= 4'h1) && (r.code.duty <= 4'h1)
                && (r.code.frange <= 4'h2) && (r.code.absm <= 4'h1)
                && (r.code.scheme == 4'h0 || r.code.scheme == 4'h2 || r.code.scheme == 4'h3);

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    n = r;
    n.dstart = 1'b0;
    stp = 1'b0;
    dec = 1'b0;
    nk = r.k;
    nspd = r.spd;
    // Answer one cycle after the request shows up
    n.ack = req & ~r.ack;
    if (req & ~r.ack) n.rdata = rdmux(r, avs_address);
    // Register writes; table and position refused during a move
    if (wr) begin
      case (avs_address)
        A_PCW: begin
          n.pcw = wm[15:0];
          if (wm[PCW_CH]) n.copy1 = wm[15:0]; // [RULE3]
          else n.copy0 = wm[15:0];            // [RULE3]
        end
        A_CODE:  if (!r.busy) n.code = wm[23:0];
        A_F0:    if (!r.busy) n.f0 = wm;
        A_FMAX:  if (!r.busy) n.fmax = wm;
        A_RAMP:  if (!r.busy) n.ramp = wm[15:0];
        A_TGT:   if (!r.busy) n.tgt = wm;
        A_POSL:  if (!r.busy && avs_byteenable == 4'hF) n.pos = avs_writedata; // [RULE2]
        default: ;
      endcase
    end
    case (r.st)
      S_IDLE: begin
        if (go) begin
          n.done = 1'b0;
          n.err = !mode_ok;
          if (mode_ok && diff == 32'h0) n.done = 1'b1;
          else if (mode_ok) begin
            n.busy = 1'b1;
            n.dir = !diff[31]; // [RULE17] [RULE18]
            n.remain = mag;
            n.k = 7'h0;
            n.acc = 32'h0;
            n.upd = 1'b0;
            n.mscnt = 32'h0;
            n.msn = 32'h0;
            n.st = S_DSTEP;
            n.dstart = 1'b1;
            n.dnum = {16'h0000, r.ramp} + nst32 - 32'h1; // [RULE13]
            n.dden = nst32;
          end
        end
      end
      S_DSTEP: begin
        if (ddone) begin
          n.stepms = (dq == 32'h0) ? 32'h1 : dq;
          n.st = S_DDELTA;
          n.dstart = 1'b1;
          n.dnum = (r.fmax > r.f0) ? (r.fmax - r.f0) : 32'h0;
          n.dden = nst32;
        end
      end
      S_DDELTA: begin
        if (ddone) begin
          n.delta = dq;
          n.spd = r.f0;
          n.st = S_DPER;
          n.dstart = 1'b1;
          n.dnum = CLK_HZ;
          n.dden = clampf(r.code.frange, r.f0); // [RULE8]
        end
      end
      S_DPER: begin
        if (ddone) begin
          // Setting of one means 1.5 Hz [RULE10]
          n.per = (clampf(r.code.frange, r.spd) == 32'h1) ? 32'(PER_SLOW) : dq;
          n.pcnt = 32'h0;
          n.st = S_RUN;
        end
      end
      S_RUN: begin
        // Stop freezes the move; resumes where it left off
        if (!stop) begin
          n.mscnt = r.mscnt + 32'h1;
          if (r.mscnt == 32'(MS_CYCLES - 1)) begin
            n.mscnt = 32'h0;
            n.msn = r.msn + 32'h1;
            if (r.msn == r.stepms - 32'h1) begin
              n.msn = 32'h0;
              stp = 1'b1;
            end
          end
          if (stp) n.upd = 1'b1;
          if (endp) begin
            n.pcnt = 32'h0;
            n.remain = r.remain - 32'h1;
            n.pos = r.dir ? (r.pos + 32'h1) : (r.pos - 32'h1); // [RULE20]
            dec = (r.remain - 32'h1) <= r.acc; // [RULE4]
            if (r.k < nst && !dec) n.acc = r.acc + 32'h1;
            if (r.remain == 32'h1) begin
              n.st = S_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1; // [RULE4]
            end else if (r.upd || stp) begin
              n.upd = 1'b0;
              if (dec) nk = (r.k != 7'h0) ? (r.k - 7'h1) : 7'h0;
              else if (r.k < nst) nk = r.k + 7'h1;
              nspd = (nk == nst) ? r.fmax : (r.f0 + 32'(nk * r.delta)); // [RULE4]
              n.k = nk;
              if (nspd != r.spd) begin
                n.spd = nspd;
                n.st = S_DPER;
                n.dstart = 1'b1;
                n.dnum = CLK_HZ;
                n.dden = clampf(r.code.frange, nspd); // [RULE8]
              end
            end
          end else begin
            n.pcnt = r.pcnt + 32'h1;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
    // Output scheme per mode digit
    n.pl = (r.st == S_RUN) && !stop && (r.pcnt < hi);
    case (r.code.scheme)
      4'h0: begin
        n.fwd = r.pl & r.dir;  // [RULE9]
        n.rev = r.pl & ~r.dir;
      end
      4'h2: begin
        n.fwd = r.pl;
        n.rev = ~r.dir; // [RULE9]
      end
      4'h3: begin
        n.fwd = r.pl;
        n.rev = r.dir; // [RULE9]
      end
      default: begin
        n.fwd = 1'b0;
        n.rev = 1'b0;
      end
    endcase
  end

  // Registered state
  always_ff @(posedge clk) begin
    if (sys_rst) r <= ST_RST;
    else if (ce) r <= n;
  end

  tpp_div u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .start   (r.dstart),
    .num     (r.dnum),
    .den     (r.dden),
    .done    (ddone),
    .quot    (dq)
  );

  assign avs_waitrequest = req & ~(r.ack & ce);
  assign avs_readdata = r.rdata;
  assign forward_pulse_out = r.fwd;
  assign reverse_pulse_out = r.rev;
  assign positioning_busy = r.busy;

  // ****************************************************
  // Checks
  // ****************************************************
  // High-time counter; all ones marks a pulse cut by stop
  logic [31:0] hcnt;
  always_ff @(posedge clk) begin
    if (sys_rst) hcnt <= 32'h0;
    else if (ce && stop) hcnt <= 32'hFFFFFFFF;
    else if (ce && !r.pl) hcnt <= 32'h0;
    else if (ce && hcnt != 32'hFFFFFFFF) hcnt <= hcnt + 32'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  copy_store_a: assert property ((avs_write && !avs_waitrequest && avs_address == A_PCW // [RULE3]
    && avs_byteenable == 4'hF && !avs_writedata[0]) |=> r.copy0 == $past(avs_writedata[15:0]))
    else $error("channel copy not stored");
  pos_load_a: assert property ((avs_write && !avs_waitrequest && avs_address == A_POSL // [RULE2]
    && avs_byteenable == 4'hF && !r.busy) |=> r.pos == $past(avs_writedata))
    else $error("position load lost");
  pos_step_a: assert property ((ce && r.st == S_RUN && !stop && endp) // [RULE20]
    |=> r.pos == ($past(r.dir) ? $past(r.pos) + 32'h1 : $past(r.pos) - 32'h1))
    else $error("position step wrong");
  end_count_a: assert property ((ce && r.st == S_RUN && !stop && endp && r.remain == 32'h1) // [RULE4]
    |=> (r.st == S_IDLE && r.done && !r.busy))
    else $error("move did not end at count");
  top_speed_a: assert property ((r.st == S_RUN && r.k == nst) |-> r.spd == r.fmax) // [RULE6]
    else $error("full step count not at max speed");
  duty_time_a: assert property ((ce && r.pl && !n.pl && !stop && hcnt != 32'hFFFFFFFF) // [RULE7]
    |-> hcnt + 32'h1 == hi)
    else $error("pulse high time wrong");
  range_clamp_a: assert property ((r.st == S_DPER) |-> clampf(r.code.frange, r.dden) == r.dden) // [RULE8]
    else $error("speed outside range");
  dir_level_a: assert property ((r.st == S_RUN && r.code.scheme == 4'h2) ##1 (r.st == S_RUN) // [RULE9]
    |-> reverse_pulse_out == !r.dir)
    else $error("direction level wrong");
  ccw_quiet_a: assert property ((r.code.scheme == 4'h0 && r.dir) ##1 r.dir |-> !reverse_pulse_out) // [RULE17]
    else $error("reverse pulse on forward move");
  inc_start_a: assert property ((ce && go && mode_ok && !r.code.absm[0] && r.tgt != 32'h0) // [RULE14]
    |=> (r.remain == $past(mag) && r.dir == !$past(r.tgt[31])))
    else $error("incremental count or direction wrong");
  abs_start_a: assert property ((ce && go && mode_ok && r.code.absm[0] && r.tgt != r.pos) // [RULE18]
    |=> r.dir == ($signed($past(r.tgt)) > $signed($past(r.pos))))
    else $error("absolute direction wrong");
  ramp_round_a: assert property ((ce && r.st == S_DSTEP && ddone && r.ramp != 16'h0) // [RULE13]
    |=> (32'(r.stepms * nst32) >= {16'h0, r.ramp} && 32'((r.stepms - 32'h1) * nst32) < {16'h0, r.ramp}))
    else $error("ramp time not rounded up");
  code_read_a: assert property ((avs_read && !avs_waitrequest && avs_address == A_CODE) // [RULE19]
    |-> avs_readdata[31:20] == 12'h000)
    else $error("control word top digits not zero");

  run_inc_c: cover property (go && mode_ok && !r.code.absm[0] ##1 r.busy);
  run_abs_c: cover property (r.code.absm[0] && r.st == S_RUN ##1 r.done);
  stop_hold_c: cover property (r.st == S_RUN && stop);
  speed_up_c: cover property (r.st == S_RUN ##1 r.st == S_DPER);

endmodule // tpp_positioner

// File: tpp_drv_model.sv
// Behavioural pulse-input motor driver that counts the steps it receives.
// Assumes outputs of the positioner on the same clock; clr starts a move.
`timescale 1ns/1ps
module tpp_drv_model (
  input  wire logic               clk,    // System clock
  input  wire logic               clr,    // Clear counters
  input  wire logic [3:0]         scheme, // Low mode digit
  input  wire logic               fwd,    // Forward pulse line
  input  wire logic               rev,    // Reverse pulse or direction
  output logic signed [31:0]      steps,  // Net step count
  output logic [31:0]             hi_len  // First pulse high cycles
);
  // ****************************************************
  // Step counting
  // ****************************************************
  logic        fwd_q;
  logic        rev_q;
  logic        got;
  logic [31:0] run;
  wire         pl = fwd | ((scheme == 4'h0) & rev);
  wire         back = (scheme == 4'h2) ? rev : ((scheme == 4'h3) ? !rev : 1'b0);
  // Direction level is read at the pulse edge, as a real driver does
  always @(posedge clk) begin
    fwd_q <= fwd;
    rev_q <= rev;
    run   <= pl ? run + 32'h1 : 32'h0;
    if (clr) begin
      steps <= 0;
      got   <= 1'b0;
    end else begin
      if (fwd && !fwd_q) steps <= back ? steps - 1 : steps + 1;
      if (scheme == 4'h0 && rev && !rev_q) steps <= steps - 1;
      if (!pl && run != 32'h0 && !got) begin
        hi_len <= run;
        got    <= 1'b1;
      end
    end
  end
endmodule // tpp_drv_model

// File: tpp_positioner_test.sv
// Self-checking bench for the positioner, driving its Avalon-MM port.
// Assumes one 100 MHz clock and the driver model on the pulse outputs.
`timescale 1ns/1ps
module trapezoid_pulse_positioner_test;
  import tpp_pkg::*;
  localparam int PSLOW = 1000;
  logic        clk = 1'b0;
  logic        sys_rst, ce, avs_read, avs_write, clr, fwd, rev, busy, wreq;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, hi_len, pos, tgt, per, seed;
  logic [3:0]  avs_byteenable, scheme;
  logic signed [31:0] steps, d;
  logic [63:0] expq[$];
  int          fail_count = 0;
  int          check_count = 0;
  always #5 clk = ~clk;

  tpp_positioner #(.MS_CYCLES(100), .PER_SLOW(PSLOW)) tpp_positioner_i (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(wreq), .forward_pulse_out(fwd),
    .reverse_pulse_out(rev), .positioning_busy(busy));
  tpp_drv_model tpp_drv_model_i (
    .clk(clk), .clr(clr), .scheme(scheme), .fwd(fwd), .rev(rev), .steps(steps), .hi_len(hi_len));

  // ****************************************************
  // Checking and closing
  // ****************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Read data taken at the edge that samples waitrequest low, oldest note first
  always @(posedge clk) begin
    if (avs_read && !wreq) begin
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else chk(avs_readdata & expq[0][31:0], expq[0][63:32] & expq[0][31:0]);
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end

  // ****************************************************
  // Bus master
  // ****************************************************
  // Request held until the rising edge that samples waitrequest low, released there
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat, input logic [3:0] be,
                     input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk);
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_address    <= a;
    avs_writedata  <= dat;
    avs_byteenable <= be;
    if (!wr) expq.push_back({e, m});
    do begin
      @(posedge clk);
      n++;
    end while (wreq && n < 50);
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] dat, input logic [3:0] be);
    bus(1'b1, a, dat, be, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, 4'hF, e, m);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  logic [5:0]  ra[6] = '{A_PCW, A_COPY0, A_COPY1, A_STAT, A_POSL, 6'h30};
  logic [23:0] mc[8] = '{24'h000000, 24'h000002, 24'h000003, 24'h000010,
                         24'h000012, 24'h000013, 24'h001100, 24'h011100};
  initial begin
    int n;
    seed = 32'h128A8;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, clr, scheme} = '0;
    ce      = 1'b1;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wr(6'h3C, rnd(), 4'hF);
    foreach (ra[k]) rd(ra[k], 32'h0, 32'hFFFFFFFF);
    // Control word copies kept per addressed channel
    wr(A_PCW, 32'h0101, 4'hF);
    rd(A_COPY1, 32'h0101, 32'hFFFF);
    wr(A_PCW, 32'h0000, 4'hF);
    rd(A_COPY0, 32'h0, 32'hFFFF);
    rd(A_COPY1, 32'h0101, 32'hFFFF);
    // Position loads only by a full double-word write
    pos = 32'h12345678;
    wr(A_POSL, pos, 4'hF);
    wr(A_POSL, rnd(), 4'h3);
    wr(A_POSH, rnd(), 4'hF);
    rd(A_POSL, 32'h5678, 32'hFFFF);
    rd(A_POSH, 32'h1234, 32'hFFFF);
    // Non-zero top digit is refused with an error and no move
    wr(A_CODE, 32'h100000, 4'hF);
    wr(A_START, 32'h1, 4'hF);
    rd(A_STAT, 32'h4, 32'h5);
    // Every output scheme in both modes, then both ramp step counts
    foreach (mc[i]) begin
      per = (i < 6) ? PSLOW : CLK_HZ / 30000;
      d   = (i < 6) ? ((rnd() % 3) + 1) : 6;
      if (i % 2 == 1) d = -d;
      tgt = mc[i][4] ? pos + d : d;
      scheme <= mc[i][3:0];
      wr(A_CODE, 32'(mc[i]), 4'hF);
      wr(A_F0, (i < 6) ? 32'h1 : 32'd30000, 4'hF);
      wr(A_FMAX, (i < 6) ? 32'h1 : 32'd100000, 4'hF);
      wr(A_RAMP, (i < 6) ? 32'd30000 : ((i == 6) ? 32'd30 : 32'd60), 4'hF);
      wr(A_TGT, tgt, 4'hF);
      clr <= 1'b1;
      wr(A_START, 32'h1, 4'hF);
      clr <= 1'b0;
      // Clock enable dropped mid-move must only delay it
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      // Stop before the first pulse freezes the move without cutting a pulse
      if (i == 6) begin
        wr(A_PCW, 32'h8, 4'hF);
        repeat (300) @(posedge clk);
        chk({31'h0, fwd}, 32'h0);
        rd(A_STAT, 32'h9, 32'h9);
        wr(A_PCW, 32'h0, 4'hF);
      end
      n = 0;
      while (busy !== 1'b0 && n < 60000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 60000) begin
        fail_count++;
        tally_and_finish();
      end
      pos = pos + d;
      chk(steps, d);
      per = mc[i][12] ? per / 4 : per / 2;
      chk(32'((hi_len + 1 - per) <= 2), 32'h1);
      rd(A_STAT, 32'h2, 32'h3);
      rd(A_POSL, {16'h0, pos[15:0]}, 32'hFFFF);
      rd(A_POSH, {16'h0, pos[31:16]}, 32'hFFFF);
    end
    tally_and_finish();
  end
endmodule // trapezoid_pulse_positioner_test
